// *** fsc_host.sv ***
// Host controller that issues flash command sequences and polls write status.
`timescale 1ns/1ps
module fsc_host #(
  parameter int STROBE_CYC = fsc_pkg::STROBE_CYC
) (
  input  wire logic                       clock_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       cmd_valid_in,
  input  wire fsc_pkg::fsc_cmd_t          cmd_in,
  output logic                            cmd_ready_out,
  output logic                            done_out,
  output fsc_pkg::fsc_result_t            result_out,
  output logic [fsc_pkg::ADDR_W-1:0]      addr_out,
  output logic                            ce_n_out,
  output logic                            oe_n_out,
  output logic                            we_n_out,
  output logic [fsc_pkg::DATA_W-1:0]      dq_out,
  output logic                            dq_oe_out,
  input  wire logic [fsc_pkg::DATA_W-1:0] dq_in
);
  import fsc_pkg::*;

  typedef enum {S_IDLE, S_SEQ, S_PRE, S_POST, S_POLL, S_FINAL, S_RESET_WR, S_DONE} fsc_state_t;

  fsc_state_t        state;
  fsc_cmd_t          cmd;
  fsc_cyc_t          cyc;
  logic [2:0]        step;
  logic              issued;
  logic              cyc_go;
  logic              cyc_done;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] last_read;
  logic              first;
  logic              retry;
  logic              fail;
  logic              late;
  logic              toggling;
  logic              needs_cycle;

  // ****************************************************************
  // Command sequence table
  // ****************************************************************
  function automatic fsc_cyc_t seq_cycle(input fsc_cmd_t c, input logic [2:0] s);
    fsc_cyc_t r;
    r.wr   = 1'b1;
    r.addr = (s == 3'h1 || s == 3'h4) ? UNLOCK_ADDR_B : UNLOCK_ADDR_A;
    r.data = (s == 3'h1 || s == 3'h4) ? UNLOCK_DATA_B : UNLOCK_DATA_A;
    unique case (c.op)
      OP_PROGRAM: begin
        if (s == 3'h2) begin
          r.data = CODE_PROGRAM;
        end else if (s == LAST_PROGRAM) begin
          r.addr = c.addr;
          r.data = c.data;
        end
      end
      OP_ERASE_SECTOR, OP_ERASE_CHIP: begin
        if (s == 3'h2) begin
          r.data = CODE_ERASE;
        end else if (s == LAST_ERASE) begin
          r.addr = (c.op == OP_ERASE_SECTOR) ? c.addr : UNLOCK_ADDR_A;
          r.data = (c.op == OP_ERASE_SECTOR) ? CODE_SECTOR : CODE_CHIP;
        end
      end
      OP_SUSPEND: begin
        r.addr = c.addr;
        r.data = CODE_SUSPEND;
      end
      OP_RESUME: begin
        r.addr = c.addr;
        r.data = CODE_RESUME;
      end
      OP_ERASE_ADD: begin
        r.addr = c.addr;
        r.data = CODE_SECTOR;
      end
      default: begin
        r.addr = c.addr;
        r.data = CODE_RESET;
      end
    endcase
    return r;
  endfunction

  function automatic logic [2:0] seq_last(input fsc_op_t op);
    unique case (op)
      OP_PROGRAM:                    return LAST_PROGRAM;
      OP_ERASE_SECTOR, OP_ERASE_CHIP: return LAST_ERASE;
      default:                       return 3'h0;
    endcase
  endfunction

  function automatic logic op_polls(input fsc_op_t op);
    return op == OP_PROGRAM || op == OP_ERASE_SECTOR || op == OP_ERASE_CHIP ||
           op == OP_SUSPEND;
  endfunction

  // ****************************************************************
  // Bus cycle request
  // ****************************************************************
  // Status reads always go to the command address, which for an erase is
  // the erasing sector itself; a chip erase polls the sector the user names.
  always_comb begin
    cyc         = '{wr: 1'b0, addr: cmd.addr, data: '0};
    needs_cycle = 1'b1;
    unique case (state)
      S_SEQ:      cyc = seq_cycle(cmd, step);
      S_RESET_WR: cyc = '{wr: 1'b1, addr: cmd.addr, data: CODE_RESET};
      S_IDLE,
      S_DONE:     needs_cycle = 1'b0;
      default:    cyc.wr = 1'b0;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cyc_go <= 1'b0;
      issued <= 1'b0;
    end else begin
      cyc_go <= needs_cycle && !issued && !cyc_go;
      if (cyc_go) begin
        issued <= 1'b1;
      end else if (cyc_done) begin
        issued <= 1'b0;
      end
    end
  end

  assign toggling = last_read[PRIMARY_TOGGLE_BIT] ^ rdata[PRIMARY_TOGGLE_BIT];

  // ****************************************************************
  // Operation sequencer
  // ****************************************************************
  // A toggling result with the fail bit set is checked once more, because the
  // toggle may stop in the same moment that the fail bit rises.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state         <= S_IDLE;
      cmd           <= '0;
      step          <= 3'h0;
      last_read     <= '0;
      first         <= 1'b1;
      retry         <= 1'b0;
      fail          <= 1'b0;
      late          <= 1'b0;
      cmd_ready_out <= 1'b0;
      done_out      <= 1'b0;
      result_out    <= '0;
    end else begin
      done_out      <= 1'b0;
      cmd_ready_out <= (state == S_IDLE) && !(cmd_valid_in && cmd_ready_out);
      unique case (state)
        S_IDLE: begin
          if (cmd_valid_in && cmd_ready_out) begin
            cmd   <= cmd_in;
            step  <= 3'h0;
            first <= 1'b1;
            retry <= 1'b0;
            fail  <= 1'b0;
            late  <= 1'b0;
            if (cmd_in.op == OP_READ) begin
              state <= S_FINAL;
            end else if (cmd_in.op == OP_ERASE_ADD) begin
              state <= S_PRE;
            end else begin
              state <= S_SEQ;
            end
          end
        end
        S_PRE: begin
          if (cyc_done) begin
            if (rdata[ERASE_TIMER_BIT]) begin
              late  <= 1'b1;
              state <= S_DONE;
            end else begin
              state <= S_SEQ;
            end
          end
        end
        S_SEQ: begin
          if (cyc_done) begin
            if (step != seq_last(cmd.op)) begin
              step <= step + 3'h1;
            end else if (op_polls(cmd.op)) begin
              state <= S_POLL;
            end else if (cmd.op == OP_ERASE_ADD) begin
              state <= S_POST;
            end else begin
              state <= S_DONE;
            end
          end
        end
        S_POST: begin
          if (cyc_done) begin
            late  <= rdata[ERASE_TIMER_BIT];
            state <= S_DONE;
          end
        end
        S_POLL: begin
          if (cyc_done) begin
            last_read <= rdata;
            first     <= 1'b0;
            if (!first) begin
              if (!toggling) begin
                state <= S_FINAL;
              end else if (rdata[TIME_LIMIT_FAIL_BIT] && retry) begin
                fail  <= 1'b1;
                state <= S_RESET_WR;
              end else if (rdata[TIME_LIMIT_FAIL_BIT]) begin
                retry <= 1'b1;
                first <= 1'b1;
              end
            end
          end
        end
        S_FINAL: begin
          if (cyc_done) begin
            result_out.data <= rdata;
            if (cmd.op == OP_PROGRAM && rdata[DATA_POLL_BIT] != cmd.data[DATA_POLL_BIT]) begin
              fail <= 1'b1;
            end
            state <= S_DONE;
          end
        end
        S_RESET_WR: begin
          if (cyc_done) begin
            state <= S_DONE;
          end
        end
        S_DONE: begin
          result_out.fail <= fail;
          result_out.late <= late;
          done_out        <= 1'b1;
          state           <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Pin cycle engine
  // ****************************************************************
  fsc_cycle #(
    .STROBE_CYC (STROBE_CYC)
  ) u_cycle (
    .clock_in  (clock_in),
    .rst_n_in  (rst_n_in),
    .go_in     (cyc_go),
    .cyc_in    (cyc),
    .done_out  (cyc_done),
    .rdata_out (rdata),
    .addr_out  (addr_out),
    .ce_n_out  (ce_n_out),
    .oe_n_out  (oe_n_out),
    .we_n_out  (we_n_out),
    .dq_out    (dq_out),
    .dq_oe_out (dq_oe_out),
    .dq_in     (dq_in)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_reread_after_stop: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state == S_POLL && cyc_done && !first && !toggling |=> state == S_FINAL ##[1:60] cyc_go)
    else $error("Final data was not re-read after the toggle stopped.");

  chk_fail_resets: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state == S_POLL && cyc_done && !first && toggling && rdata[TIME_LIMIT_FAIL_BIT] && retry
    |=> state == S_RESET_WR ##[1:60] (we_n_out == 1'b0 && dq_out == CODE_RESET))
    else $error("Failed operation did not issue the reset command.");

  chk_poll_address: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state == S_POLL && !ce_n_out |-> we_n_out && addr_out == cmd.addr)
    else $error("Status poll aimed away from the command address.");

  chk_done_pulse: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    done_out |=> !done_out && state == S_IDLE)
    else $error("Done was not a single-cycle pulse.");

endmodule

// *** fsc_pkg.sv ***
// Shared constants and carrier types for the flash status-polling controller.
package fsc_pkg;

  // ****************************************************************
  // Widths and pin timing
  // ****************************************************************
  localparam int ADDR_W        = 22;
  localparam int DATA_W        = 8;
  localparam int CLK_PERIOD_NS = 4;
  // Longest read access time of the part; strobes are held at least this long.
  localparam int STROBE_NS     = 120;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Status bit positions
  // ****************************************************************
  localparam int DATA_POLL_BIT       = 7;
  localparam int PRIMARY_TOGGLE_BIT  = 6;
  localparam int TIME_LIMIT_FAIL_BIT = 5;
  localparam int ERASE_TIMER_BIT     = 3;
  localparam int SECTOR_TOGGLE_BIT   = 2;

  // ****************************************************************
  // Command cycles
  // ****************************************************************
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_A = 22'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_B = 22'h0002aa;
  localparam logic [DATA_W-1:0] UNLOCK_DATA_A = 8'haa;
  localparam logic [DATA_W-1:0] UNLOCK_DATA_B = 8'h55;
  localparam logic [DATA_W-1:0] CODE_PROGRAM  = 8'ha0;
  localparam logic [DATA_W-1:0] CODE_ERASE    = 8'h80;
  localparam logic [DATA_W-1:0] CODE_SECTOR   = 8'h30;
  localparam logic [DATA_W-1:0] CODE_CHIP     = 8'h10;
  localparam logic [DATA_W-1:0] CODE_SUSPEND  = 8'hb0;
  localparam logic [DATA_W-1:0] CODE_RESUME   = 8'h30;
  localparam logic [DATA_W-1:0] CODE_RESET    = 8'hf0;
  localparam logic [2:0]        LAST_PROGRAM  = 3'h3;
  localparam logic [2:0]        LAST_ERASE    = 3'h5;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_READ, OP_PROGRAM, OP_ERASE_SECTOR, OP_ERASE_CHIP,
    OP_SUSPEND, OP_RESUME, OP_RESET, OP_ERASE_ADD
  } fsc_op_t;

  typedef struct packed {
    fsc_op_t           op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fsc_cmd_t;

  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fsc_cyc_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              fail;
    logic              late;
  } fsc_result_t;

endpackage

// *** fsc_cycle.sv ***
// Single asynchronous bus cycle generator for the flash pins.
`timescale 1ns/1ps
module fsc_cycle #(
  parameter int STROBE_CYC = fsc_pkg::STROBE_CYC
) (
  input  wire logic                      clock_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      go_in,
  input  wire fsc_pkg::fsc_cyc_t         cyc_in,
  output logic                           done_out,
  output logic [fsc_pkg::DATA_W-1:0]     rdata_out,
  output logic [fsc_pkg::ADDR_W-1:0]     addr_out,
  output logic                           ce_n_out,
  output logic                           oe_n_out,
  output logic                           we_n_out,
  output logic [fsc_pkg::DATA_W-1:0]     dq_out,
  output logic                           dq_oe_out,
  input  wire logic [fsc_pkg::DATA_W-1:0] dq_in
);
  import fsc_pkg::*;

  typedef enum {C_IDLE, C_SETUP, C_STROBE, C_RELEASE} fsc_cstate_t;

  fsc_cstate_t cstate;
  logic [7:0]  count;
  logic        wr;

  // ****************************************************************
  // Cycle sequencing
  // ****************************************************************
  // Address moves only in idle, where chip enable is already high, so the
  // toggle bits are never advanced by a bank change under an active read.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cstate    <= C_IDLE;
      count     <= 8'h00;
      wr        <= 1'b0;
      done_out  <= 1'b0;
      rdata_out <= '0;
      addr_out  <= '0;
      ce_n_out  <= 1'b1;
      oe_n_out  <= 1'b1;
      we_n_out  <= 1'b1;
      dq_out    <= '0;
      dq_oe_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      unique case (cstate)
        C_IDLE: begin
          if (go_in) begin
            addr_out  <= cyc_in.addr;
            dq_out    <= cyc_in.data;
            wr        <= cyc_in.wr;
            dq_oe_out <= cyc_in.wr;
            cstate    <= C_SETUP;
          end
        end
        C_SETUP: begin
          ce_n_out <= 1'b0;
          oe_n_out <= wr;
          we_n_out <= !wr;
          count    <= 8'(STROBE_CYC - 1);
          cstate   <= C_STROBE;
        end
        C_STROBE: begin
          if (count == 8'h00) begin
            rdata_out <= dq_in;
            oe_n_out  <= 1'b1;
            we_n_out  <= 1'b1;
            cstate    <= C_RELEASE;
          end else begin
            count <= count - 8'h01;
          end
        end
        C_RELEASE: begin
          ce_n_out  <= 1'b1;
          dq_oe_out <= 1'b0;
          done_out  <= 1'b1;
          cstate    <= C_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_addr_ce_high: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $changed(addr_out) |-> $past(ce_n_out) && ce_n_out)
    else $error("Address changed while chip enable was low.");

  chk_oe_we_excl: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !we_n_out |-> oe_n_out && dq_oe_out)
    else $error("Output and write enables overlap or data not driven.");

endmodule

// *** fsc_flash_model.sv ***
// Behavioural flash device that answers the host's command and status reads.
`timescale 1ns/1ps
module fsc_flash_model #(
  parameter int PROG_READS  = 3,
  parameter int ERASE_READS = 8,
  parameter int TIMER_READS = 2
) (
  input  wire logic [fsc_pkg::ADDR_W-1:0] addr_in,
  input  wire logic                       ce_n_in,
  input  wire logic                       oe_n_in,
  input  wire logic                       we_n_in,
  input  wire logic [fsc_pkg::DATA_W-1:0] dq_in,
  output logic      [fsc_pkg::DATA_W-1:0] dq_out
);
  import fsc_pkg::*;
  // ********************
  // Device state
  // ********************
  typedef enum {MD_IDLE, MD_PROG, MD_ERASE, MD_LOCK} fsc_md_t;
  localparam int PROT_SECT = 63;
  fsc_md_t     mode = MD_IDLE;
  logic [7:0]  mem [int];
  bit   [63:0] erased = '0;
  bit   [63:0] esect = '0;
  logic [21:0] paddr;
  logic [7:0]  pdata;
  logic [1:0]  bank;
  logic        t6 = 1'b0;
  logic        t2 = 1'b0;
  logic        drv = 1'b0;
  int          seq = 0;
  int          reads = 0;
  int          left;
  int          ks[$];
  initial dq_out = 8'h00;

  function automatic logic [7:0] arr(logic [21:0] a);
    if (mem.exists(a)) return mem[a];
    return erased[a[21:16]] ? 8'hff : a[7:0] ^ a[21:14];
  endfunction

  task automatic start(fsc_md_t m, logic [21:0] a, logic [7:0] d);
    bank = a[21:20];
    paddr = a;
    pdata = d;
    reads = 0;
    mode = m;
    left = (m == MD_ERASE) ? ERASE_READS : PROG_READS;
    if (m == MD_PROG && a[21:16] == PROT_SECT) left = 1;
    else if (m == MD_PROG && (arr(a) & d) != d) mode = MD_LOCK;
  endtask

  task automatic finish();
    if (mode == MD_PROG && paddr[21:16] != PROT_SECT) mem[paddr] = pdata;
    if (mode == MD_ERASE) begin
      esect[PROT_SECT] = 1'b0;
      erased |= esect;
      ks.delete();
      foreach (mem[k]) if (esect[k[21:16]]) ks.push_back(k);
      foreach (ks[i]) mem.delete(ks[i]);
    end
    esect = '0;
    mode = MD_IDLE;
  endtask

  // ********************
  // Pin cycles
  // ********************
  always @(posedge we_n_in) begin
    if (!ce_n_in) begin
      if (dq_in == CODE_RESET && mode == MD_LOCK) mode = MD_IDLE;
      if (mode == MD_ERASE && seq == 0 && dq_in == CODE_SECTOR) begin
        if (reads < TIMER_READS) esect[addr_in[21:16]] = 1'b1;
      end
      if (seq == 3) start(MD_PROG, addr_in, dq_in);
      if (seq == 6 && (dq_in == CODE_SECTOR || dq_in == CODE_CHIP)) begin
        esect = (dq_in == CODE_CHIP) ? '1 : 64'h1 << addr_in[21:16];
        start(MD_ERASE, addr_in, dq_in);
      end
      case (seq)
        0, 4: seq = (dq_in == UNLOCK_DATA_A) ? seq + 1 : 0;
        1, 5: seq = (dq_in == UNLOCK_DATA_B) ? seq + 1 : 0;
        2: seq = (dq_in == CODE_PROGRAM) ? 3 : (dq_in == CODE_ERASE) ? 4 : 0;
        default: seq = 0;
      endcase
    end
  end

  // A status byte is built at the falling strobe, so each read advances the toggles once.
  always @(negedge oe_n_in or negedge ce_n_in) begin
    if (!oe_n_in && !ce_n_in) begin
      drv = 1'b1;
      if (mode != MD_IDLE && addr_in[21:20] == bank) begin
        t6 = ~t6;
        reads++;
        if (esect[addr_in[21:16]]) t2 = ~t2;
        if (mode == MD_ERASE) dq_out = {2'b00, 3'b000, t2, 2'b00};
        else dq_out = {~pdata[7], 1'b0, reads > 2 && mode == MD_LOCK, 5'b00100};
        dq_out[6] = t6;
        if (mode == MD_ERASE) dq_out[3] = reads > TIMER_READS;
        if (mode != MD_LOCK && reads >= left) finish();
      end else begin
        dq_out = arr(addr_in);
      end
    end
  end

  // A released bus shows the inverse of the last byte, never a stale copy.
  always @(posedge oe_n_in or posedge ce_n_in) begin
    if (drv) begin
      dq_out = ~dq_out;
      drv = 1'b0;
    end
  end
endmodule

// *** fsc_host_bench.sv ***
// Self-checking bench for the flash status-polling host controller.
`timescale 1ns/1ps
module fsc_host_bench;
  import fsc_pkg::*;
  localparam logic [21:0] PROT_ADDR = 22'h3f0012;
  localparam logic [21:0] HARD_ADDR = 22'h100000;
  logic        clock_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        cmd_valid_in = 1'b0;
  fsc_cmd_t    cmd_in = '0;
  logic        cmd_ready_out, done_out, ce_n_out, oe_n_out, we_n_out, dq_oe_out;
  fsc_result_t result_out;
  logic [21:0] addr_out, a, s;
  logic [7:0]  dq_out, dev_q, dq_in, d, e;
  int          fail_count = 0;
  int          total_checks = 0;
  int          seed = 32'h39691903;
  logic [7:0]  ref_mem [int];
  bit   [63:0] ref_er = '0;
  fsc_op_t     ops [4] = '{OP_SUSPEND, OP_RESUME, OP_RESET, OP_ERASE_ADD};

  assign dq_in = dq_oe_out ? dq_out : dev_q;
  initial begin
    forever #2 clock_in = ~clock_in;
  end

  fsc_host #(.STROBE_CYC(3)) dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out),
    .done_out(done_out), .result_out(result_out), .addr_out(addr_out),
    .ce_n_out(ce_n_out), .oe_n_out(oe_n_out), .we_n_out(we_n_out),
    .dq_out(dq_out), .dq_oe_out(dq_oe_out), .dq_in(dq_in));
  fsc_flash_model dev (.addr_in(addr_out), .ce_n_in(ce_n_out), .oe_n_in(oe_n_out),
    .we_n_in(we_n_out), .dq_in(dq_out), .dq_out(dev_q));

  // ********************
  // Helpers
  // ********************
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [7:0] ref_rd(logic [21:0] x);
    if (ref_mem.exists(x)) return ref_mem[x];
    return ref_er[x[21:16]] ? 8'hff : x[7:0] ^ x[21:14];
  endfunction

  // The bound is generous because polling has no fixed length.
  task automatic run(fsc_op_t op, logic [21:0] x, logic [7:0] y);
    int n;
    n = 0;
    @(posedge clock_in);
    cmd_valid_in <= 1'b1;
    cmd_in <= {op, x, y};
    @(posedge clock_in);
    while (cmd_ready_out !== 1'b1 && n < 100) begin
      @(posedge clock_in);
      n++;
    end
    cmd_valid_in <= 1'b0;
    while (done_out !== 1'b1 && n < 50000) begin
      @(posedge clock_in);
      n++;
    end
    if (n >= 50000) begin
      fail_count++;
      results();
    end
    repeat (2) @(posedge clock_in);
  endtask

  task automatic rd(logic [21:0] x);
    run(OP_READ, x, 8'h00);
    check("read data", result_out.data, ref_rd(x));
  endtask

  // ********************
  // Scenarios
  // ********************
  initial begin
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    for (int i = 0; i < 4; i++) begin
      a = 22'($random(seed));
      a[21:20] = i[1:0];
      rd(a);
    end
    s = 22'($random(seed));
    s[21:20] = 2'b00;
    run(OP_ERASE_SECTOR, s, 8'h00);
    ref_er[s[21:16]] = 1'b1;
    check("erase data", result_out.data, 8'hff);
    check("erase fail", {7'h00, result_out.fail}, 8'h00);
    rd({s[21:16], 16'($random(seed))});
    for (int i = 0; i < 3; i++) begin
      a = {s[21:16], 8'(i), 8'($random(seed))};
      d = 8'($random(seed));
      run(OP_PROGRAM, a, d);
      ref_mem[a] = d;
      check("program data", result_out.data, d);
      check("program fail", {7'h00, result_out.fail}, 8'h00);
      rd(a);
    end
    run(OP_PROGRAM, HARD_ADDR, 8'hbf);
    check("locked fail", {7'h00, result_out.fail}, 8'h01);
    rd(HARD_ADDR);
    run(OP_PROGRAM, PROT_ADDR, 8'h11);
    check("protected fail", {7'h00, result_out.fail}, 8'h01);
    check("protected data", result_out.data, ref_rd(PROT_ADDR));
    run(OP_ERASE_SECTOR, PROT_ADDR, 8'h00);
    check("protected erase", result_out.data, ref_rd(PROT_ADDR));
    // An erase-add reports only the timer bit; the read data of the
    // previous command must still stand on the result port.
    foreach (ops[i]) begin
      e = ref_rd(a);
      a = 22'($random(seed));
      d = ref_rd(a);
      run(ops[i], a, 8'h00);
      if (ops[i] == OP_SUSPEND || ops[i] == OP_ERASE_ADD)
        check("idle status", result_out.data, (ops[i] == OP_ERASE_ADD) ? e : d);
      if (ops[i] == OP_ERASE_ADD)
        check("erase late", {7'h00, result_out.late}, {7'h00, d[3]});
      rd(a);
    end
    run(OP_ERASE_CHIP, s, 8'h00);
    ref_mem.delete();
    ref_er = 64'h7fff_ffff_ffff_ffff;
    check("chip erase", result_out.data, 8'hff);
    rd(HARD_ADDR);
    rd(PROT_ADDR);
    rd(22'($random(seed)));
    results();
  end
endmodule
